// [pkg/pidf_pkg.sv]
// Purpose: Shared constants for the pin input debounce filter
// Assumes: 50 MHz system clock, byte addressed register port
// Notes:   Offsets are byte addresses; 8-bit registers sit in the low bits
`default_nettype none

package pidf_pkg;

    // ********************************************************
    // Register map
    // ********************************************************
    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned PIN_COUNT = 16;
    localparam int unsigned PERIOD_W  = 8;
    localparam int unsigned SEL_W     = 2;

    localparam logic [7:0] COARSE_OFFSET = 8'h6c;
    localparam logic [7:0] MEDIUM_OFFSET = 8'h6d;
    localparam logic [7:0] FINE_OFFSET   = 8'h6e;
    localparam logic [7:0] STATUS_OFFSET = 8'h6f;
    localparam logic [7:0] SELECT_OFFSET = 8'h70;

    localparam logic [7:0]  COARSE_RESET = 8'h0a;
    localparam logic [7:0]  MEDIUM_RESET = 8'h0a;
    localparam logic [7:0]  FINE_RESET   = 8'h0a;
    localparam logic [31:0] SELECT_RESET = 32'h00000000;

    localparam int unsigned STATUS_PENDING_BIT = 0;

    // ********************************************************
    // Time bases
    // ********************************************************
    localparam int unsigned CLK_PERIOD_NS  = 20;
    localparam int unsigned FINE_UNIT_NS   = 1000;
    localparam int unsigned MEDIUM_UNIT_US = 1000;
    localparam int unsigned COARSE_UNIT_MS = 10;
    localparam int unsigned CYCLES_PER_US  =
        (FINE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [1:0] {
        PIDF_SEL_OFF    = 2'h0,
        PIDF_SEL_FINE   = 2'h1,
        PIDF_SEL_MEDIUM = 2'h2,
        PIDF_SEL_COARSE = 2'h3
    } pidf_sel_type;

    typedef enum logic {
        PIDF_ST_STABLE  = 1'h0,
        PIDF_ST_PENDING = 1'h1
    } pidf_state_type;

endpackage : pidf_pkg

`default_nettype wire

// [hdl/pidf_tick_gen.sv]
// Purpose: Shared 1 us, 1 ms and 10 ms tick strobes
// Assumes: Ticks are one-cycle pulses on clk
// Notes:   Cascaded counters keep each stage small
`default_nettype none

module pidf_tick_gen #(
    parameter int unsigned CYC_PER_US    = pidf_pkg::CYCLES_PER_US,
    parameter int unsigned US_PER_MS     = pidf_pkg::MEDIUM_UNIT_US,
    parameter int unsigned MS_PER_COARSE = pidf_pkg::COARSE_UNIT_MS
) (
    input  wire logic clk,
    input  wire logic rst_b,
    output logic      fine_tick,
    output logic      medium_tick,
    output logic      coarse_tick
);

    localparam int unsigned PW = $clog2(CYC_PER_US + 1);
    localparam int unsigned MW = $clog2(US_PER_MS + 1);
    localparam int unsigned CW = $clog2(MS_PER_COARSE + 1);

    if (CYC_PER_US < 2 || US_PER_MS < 1 || MS_PER_COARSE < 1) begin : g_bad
        $error("pidf_tick_gen: divider values out of range");
    end

    logic [PW-1:0] pre_q;
    logic [MW-1:0] ms_q;
    logic [CW-1:0] co_q;
    logic          us_end;
    logic          ms_end;
    logic          co_end;

    assign us_end = (pre_q == PW'(CYC_PER_US - 1));
    assign ms_end = us_end && (ms_q == MW'(US_PER_MS - 1));
    assign co_end = ms_end && (co_q == CW'(MS_PER_COARSE - 1));

    // ********************************************************
    // Counters derived from the system clock
    // ********************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_q <= '0;
            ms_q  <= '0;
            co_q  <= '0;
        end else begin
            pre_q <= us_end ? '0 : pre_q + PW'(1);
            if (us_end) begin
                ms_q <= ms_end ? '0 : ms_q + MW'(1);
            end
            if (ms_end) begin
                co_q <= co_end ? '0 : co_q + CW'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fine_tick   <= 1'b0;
            medium_tick <= 1'b0;
            coarse_tick <= 1'b0;
        end else begin
            fine_tick   <= us_end;
            medium_tick <= ms_end;
            coarse_tick <= co_end;
        end
    end

endmodule : pidf_tick_gen

`default_nettype wire

// [hdl/pidf_pin_filter.sv]
// Purpose: Debounce one synchronised pin against a shared tick
// Assumes: raw is already in the clk domain
// Notes:   Tick phase makes the filter length count or count-1 units
`default_nettype none

module pidf_pin_filter (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       raw,
    input  wire logic       enable,
    input  wire logic       tick,
    input  wire logic [7:0] period,
    output logic            filtered,
    output logic            pending
);

    pidf_pkg::pidf_state_type state_q;
    logic [7:0]               units_q;
    logic [8:0]               next_units;

    assign next_units = {1'b0, units_q} + 9'h001;
    assign pending    = (state_q == pidf_pkg::PIDF_ST_PENDING);

    // ********************************************************
    // Filter
    // ********************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q  <= pidf_pkg::PIDF_ST_STABLE;
            units_q  <= 8'h00;
            filtered <= 1'b0;
        end else if (!enable) begin
            // Unfiltered pins pass straight through
            state_q  <= pidf_pkg::PIDF_ST_STABLE;
            units_q  <= 8'h00;
            filtered <= raw;
        end else if (raw == filtered) begin
            // A bounce back cancels the pending change
            state_q <= pidf_pkg::PIDF_ST_STABLE;
            units_q <= 8'h00;
        end else begin
            case (state_q)
                pidf_pkg::PIDF_ST_STABLE: begin
                    state_q <= pidf_pkg::PIDF_ST_PENDING;
                    units_q <= 8'h00;
                end
                pidf_pkg::PIDF_ST_PENDING: begin
                    // First tick may come early: length is count-1..count
                    if (tick) begin
                        if (next_units >= {1'b0, period}) begin
                            filtered <= raw;
                            state_q  <= pidf_pkg::PIDF_ST_STABLE;
                            units_q  <= 8'h00;
                        end else begin
                            units_q <= next_units[7:0];
                        end
                    end
                end
                default: begin
                    state_q <= pidf_pkg::PIDF_ST_STABLE;
                    units_q <= 8'h00;
                end
            endcase
        end
    end

endmodule : pidf_pin_filter

`default_nettype wire

// [hdl/pidf_top.sv]
// Purpose: Sixteen-pin input debounce filter with register port
// Assumes: Pins are asynchronous; register master is on clk
// Notes:   Read data stand only in the cycle after the read strobe
//          Ticks are shared, so a period may end one unit short
//          Period 0 acts as one unit: the next tick ends it
//          Writes to status or unmapped offsets are dropped
//          Unmapped offsets read as zero
`default_nettype none

module pidf_top #(
    parameter int unsigned PINS          = pidf_pkg::PIN_COUNT,
    parameter int unsigned CYC_PER_US    = pidf_pkg::CYCLES_PER_US,
    parameter int unsigned US_PER_MS     = pidf_pkg::MEDIUM_UNIT_US,
    parameter int unsigned MS_PER_COARSE = pidf_pkg::COARSE_UNIT_MS
) (
    input  wire logic        clk,
    input  wire logic        rst_b,

    input  wire logic [15:0] pin_raw,
    output logic      [15:0] pin_filtered,
    output logic             filter_pending,

    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata
);

    // ********************************************************
    // Elaboration checks
    // ********************************************************
    // The select register layout is fixed at sixteen pins
    if (PINS != pidf_pkg::PIN_COUNT) begin : g_bad_pins
        $error("pidf_top: PINS must equal sixteen");
    end

    // Fields must fill the select word exactly
    if (pidf_pkg::SEL_W * PINS != pidf_pkg::DATA_W) begin : g_bad_fields
        $error("pidf_top: fields must fill the select word");
    end

    // The ports and period registers are fixed at these widths
    if (pidf_pkg::ADDR_W != 8 || pidf_pkg::DATA_W != 32
        || pidf_pkg::PERIOD_W != 8) begin : g_bad_widths
        $error("pidf_top: package widths do not match the ports");
    end

    // Fewer than two clocks per microsecond cannot make a fine tick
    if (CYC_PER_US < 2) begin : g_bad_us
        $error("pidf_top: CYC_PER_US must be two or more");
    end

    // An empty divider stage would stop the slower ticks
    if (US_PER_MS < 1 || MS_PER_COARSE < 1) begin : g_bad_div
        $error("pidf_top: divider stages need one unit or more");
    end

    // ********************************************************
    // Declarations
    // ********************************************************
    // Software registers
    logic [7:0]  coarse_period_count_q;
    logic [7:0]  medium_period_count_q;
    logic [7:0]  fine_period_count_q;
    logic [31:0] filter_source_select_q;

    // Pin pipeline
    logic [15:0] meta_q;
    logic [15:0] sync_q;

    // Time base
    logic        fine_tick;
    logic        medium_tick;
    logic        coarse_tick;

    // Per-pin routing and results
    logic [15:0] pin_enable;
    logic [15:0] pin_tick;
    logic [7:0]  pin_period [16];
    logic [15:0] pin_value;
    logic [15:0] pin_pend;

    // Read path
    logic        any_pending;
    logic [7:0]  status_byte;
    logic [31:0] rd_value;

    // Write decode
    logic        wr_coarse;
    logic        wr_medium;
    logic        wr_fine;
    logic        wr_select;

    // ********************************************************
    // Functions
    // ********************************************************
    // Field of one pin within the select register
    function automatic pidf_pkg::pidf_sel_type field_of(
        input logic [31:0] sel,
        input int unsigned n
    );
        field_of = pidf_pkg::pidf_sel_type'(sel[2*n +: 2]);
    endfunction : field_of

    // Tick chosen by a pin's field
    function automatic logic tick_of(
        input pidf_pkg::pidf_sel_type f,
        input logic                   t_fine,
        input logic                   t_medium,
        input logic                   t_coarse
    );
        case (f)
            pidf_pkg::PIDF_SEL_FINE:   tick_of = t_fine;
            pidf_pkg::PIDF_SEL_MEDIUM: tick_of = t_medium;
            pidf_pkg::PIDF_SEL_COARSE: tick_of = t_coarse;
            default:                   tick_of = 1'b0;
        endcase
    endfunction : tick_of

    // Period count chosen by a pin's field
    function automatic logic [7:0] period_of(
        input pidf_pkg::pidf_sel_type f,
        input logic [7:0]             p_fine,
        input logic [7:0]             p_medium,
        input logic [7:0]             p_coarse
    );
        case (f)
            pidf_pkg::PIDF_SEL_FINE:   period_of = p_fine;
            pidf_pkg::PIDF_SEL_MEDIUM: period_of = p_medium;
            pidf_pkg::PIDF_SEL_COARSE: period_of = p_coarse;
            default:                   period_of = 8'h00;
        endcase
    endfunction : period_of

    // One strobe aimed at one register offset
    function automatic logic addr_hit(
        input logic       strobe,
        input logic [7:0] addr,
        input logic [7:0] offset
    );
        addr_hit = strobe && (addr == offset);
    endfunction : addr_hit

    // Byte registers read back with zero upper bits
    function automatic logic [31:0] widen_byte(
        input logic [7:0] b
    );
        widen_byte = {24'h000000, b};
    endfunction : widen_byte

    // ********************************************************
    // Register write decode
    // ********************************************************
    // Status and unmapped offsets have no write path
    assign wr_coarse = addr_hit(reg_wr, reg_addr,
                                pidf_pkg::COARSE_OFFSET);
    assign wr_medium = addr_hit(reg_wr, reg_addr,
                                pidf_pkg::MEDIUM_OFFSET);
    assign wr_fine   = addr_hit(reg_wr, reg_addr,
                                pidf_pkg::FINE_OFFSET);
    assign wr_select = addr_hit(reg_wr, reg_addr,
                                pidf_pkg::SELECT_OFFSET);

    // ********************************************************
    // Period registers
    // ********************************************************
    // A new period applies from the next tick; a change in
    // flight may end one unit early or late.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            coarse_period_count_q <= pidf_pkg::COARSE_RESET;
        end else if (wr_coarse) begin
            coarse_period_count_q <= reg_wdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            medium_period_count_q <= pidf_pkg::MEDIUM_RESET;
        end else if (wr_medium) begin
            medium_period_count_q <= reg_wdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fine_period_count_q <= pidf_pkg::FINE_RESET;
        end else if (wr_fine) begin
            fine_period_count_q <= reg_wdata[7:0];
        end
    end

    // ********************************************************
    // Source select register
    // ********************************************************
    // A new field applies at once; a pending count carries on unless the new field is 00
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            filter_source_select_q <= pidf_pkg::SELECT_RESET;
        end else if (wr_select) begin
            filter_source_select_q <= reg_wdata;
        end
    end

    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    // Two stages; only the second stage feeds the filters
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= 16'h0000;
        end else begin
            meta_q <= pin_raw;
        end
    end

    // The first stage may be metastable; give it a full cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_q <= 16'h0000;
        end else begin
            sync_q <= meta_q;
        end
    end

    // ********************************************************
    // Shared time base
    // ********************************************************
    // Free-running, so a pin's first unit is partial
    pidf_tick_gen #(
        .CYC_PER_US    (CYC_PER_US),
        .US_PER_MS     (US_PER_MS),
        .MS_PER_COARSE (MS_PER_COARSE)
    ) u_ticks (
        .clk         (clk),
        .rst_b       (rst_b),
        .fine_tick   (fine_tick),
        .medium_tick (medium_tick),
        .coarse_tick (coarse_tick)
    );

    // ********************************************************
    // Per-pin routing
    // ********************************************************
    // Field 00 leaves a pin unfiltered with its count idle
    for (genvar n = 0; n < 16; n++) begin : g_route
        pidf_pkg::pidf_sel_type field;

        assign field         = field_of(filter_source_select_q, n);
        assign pin_enable[n] = (field != pidf_pkg::PIDF_SEL_OFF);
        assign pin_tick[n]   = tick_of(field,
                                       fine_tick,
                                       medium_tick,
                                       coarse_tick);
        assign pin_period[n] = period_of(field,
                                         fine_period_count_q,
                                         medium_period_count_q,
                                         coarse_period_count_q);
    end

    // ********************************************************
    // Per-pin filters
    // ********************************************************
    // Each pin filters alone; none waits on another
    for (genvar n = 0; n < 16; n++) begin : g_pin
        pidf_pin_filter u_filter (
            .clk      (clk),
            .rst_b    (rst_b),
            .raw      (sync_q[n]),
            .enable   (pin_enable[n]),
            .tick     (pin_tick[n]),
            .period   (pin_period[n]),
            .filtered (pin_value[n]),
            .pending  (pin_pend[n])
        );
    end

    assign pin_filtered = pin_value;

    // ********************************************************
    // Pending status
    // ********************************************************
    assign any_pending = |pin_pend;
    assign status_byte = {7'h00, any_pending};

    // The port copy lags status bit 0 by one cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            filter_pending <= 1'b0;
        end else begin
            filter_pending <= any_pending;
        end
    end

    // ********************************************************
    // Register read
    // ********************************************************
    // Data stand for one cycle only; zero otherwise, and zero
    // for addresses outside the map.
    always_comb begin
        case (reg_addr)
            pidf_pkg::COARSE_OFFSET: begin
                rd_value = widen_byte(coarse_period_count_q);
            end
            pidf_pkg::MEDIUM_OFFSET: begin
                rd_value = widen_byte(medium_period_count_q);
            end
            pidf_pkg::FINE_OFFSET: begin
                rd_value = widen_byte(fine_period_count_q);
            end
            pidf_pkg::STATUS_OFFSET: begin
                rd_value = widen_byte(status_byte);
            end
            pidf_pkg::SELECT_OFFSET: begin
                rd_value = filter_source_select_q;
            end
            default: begin
                rd_value = 32'h00000000;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata <= rd_value;
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule : pidf_top

`default_nettype wire

// [verification/pidf_checker.sv]
// Purpose: Concurrent checks on the debounce filter top ports
// Assumes: One clock domain, reset active low
// Notes:   Attached to every pidf_top by the bind at the foot
`default_nettype none

module pidf_checker (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [15:0] pin_raw,
    input wire logic [15:0] pin_filtered,
    input wire logic        filter_pending,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic mapped;
    assign mapped = (reg_addr >= 8'h6c) && (reg_addr <= 8'h70);

    // ************************************************
    // Write then read back
    // ************************************************
    sequence wr_then_rd(logic [7:0] a);
        (reg_wr && reg_addr == a) ##1 (reg_rd && reg_addr == a);
    endsequence

    property read_back(logic [7:0] a, logic [31:0] m);
        wr_then_rd(a) |-> ##1 reg_rdata == ($past(reg_wdata, 2) & m);
    endproperty

    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside a read");
    status_upper_a: assert property (
        $past(reg_rd && reg_addr == 8'h6f) |-> reg_rdata[31:1] == 31'h0)
        else $error("status upper bits not zero");
    period_upper_a: assert property (
        $past(reg_rd && reg_addr >= 8'h6c && reg_addr <= 8'h6e)
        |-> reg_rdata[31:8] == 24'h0)
        else $error("period register upper bits not zero");
    unmapped_zero_a: assert property (
        $past(reg_rd && !mapped) |-> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    coarse_back_a: assert property (read_back(8'h6c, 32'hff))
        else $error("coarse period read back wrong");
    medium_back_a: assert property (read_back(8'h6d, 32'hff))
        else $error("medium period read back wrong");
    fine_back_a: assert property (read_back(8'h6e, 32'hff))
        else $error("fine period read back wrong");
    select_back_a: assert property (
        read_back(8'h70, 32'hffffffff))
        else $error("select read back wrong");
    // A filtered pin may only move to a level the raw pin really held
    filter_src_a: assert property (
        ((pin_filtered ^ $past(pin_filtered))
         & (pin_filtered ^ $past(pin_raw, 3))) == 16'h0)
        else $error("filtered pin moved to a level not held");
    pending_flag_a: assert property (
        $past(reg_rd && reg_addr == 8'h6f) |-> reg_rdata[0] == filter_pending)
        else $error("pending port disagrees with status bit");
endmodule : pidf_checker

bind pidf_top pidf_checker pidf_checker_inst (
    .clk(clk), .rst_b(rst_b), .pin_raw(pin_raw),
    .pin_filtered(pin_filtered), .filter_pending(filter_pending),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata)
);

`default_nettype wire

// [verification/pidf_pin_src.sv]
// Purpose: Model of the signal sources wired to the filtered pins
// Assumes: Sources switch at any time, unrelated to clk
// Notes:   A fixed wire delay keeps pin edges off the clock edge
`default_nettype none

module pidf_pin_src (
    input  wire logic [15:0] level,
    output logic      [15:0] pin_raw
);
    timeunit 1ns;
    timeprecision 1ps;

    // Skew makes the pins asynchronous to the sampler, as on a board
    initial begin
        pin_raw = 16'h0;
        forever @(level) pin_raw <= #7 level;
    end
endmodule : pidf_pin_src

`default_nettype wire

// [verification/pidf_top_test.sv]
// Purpose: Self-checking bench for the pin debounce filter
// Assumes: Shortened time bases, 2 cycles per us, 4 us per ms
// Notes:   Units in cycles are 2, 8 and 16 for the three bases
`default_nettype none

module pidf_top_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int LIMIT = 20000;
    localparam int P     = 4;

    logic        clk;
    logic        rst_b;
    logic [15:0] level;
    logic [15:0] pin_raw;
    logic [15:0] pin_filtered;
    logic        filter_pending;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [31:0] v;
    int          err_count;
    int          n_tests;
    int          cyc = 0;
    int          u;
    int          k;

    pidf_top #(.CYC_PER_US(2), .US_PER_MS(4), .MS_PER_COARSE(2))
    pidf_top_inst (
        .clk(clk), .rst_b(rst_b), .pin_raw(pin_raw),
        .pin_filtered(pin_filtered), .filter_pending(filter_pending),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata)
    );

    pidf_pin_src pidf_pin_src_inst (.level(level), .pin_raw(pin_raw));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ************************************************
    // Bus and compare tasks
    // ************************************************
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic bus(input logic w, input logic r, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= w;
        reg_rd    <= r;
        reg_addr  <= a;
        reg_wdata <= d;
    endtask : bus

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus(1'b0, 1'b1, a, 32'h0);
        bus(1'b0, 1'b0, a, 32'h0);
        #1 d = reg_rdata;
    endtask : rd

    // Write and read with no gap, the tightest legal order
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] q);
        bus(1'b1, 1'b0, a, d);
        rd(a, q);
    endtask : wr_rd

    task automatic wait_pin(input logic lvl);
        k = 0;
        while (pin_filtered[15] !== lvl && k < 400) begin
            @(posedge clk);
            #1 k++;
        end
    endtask : wait_pin

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_count++;
            close_out();
        end
    end

    // ************************************************
    // Main sequence
    // ************************************************
    initial begin
        logic [7:0]  addrs [6];
        logic [31:0] exps  [6];
        addrs = '{8'h6c, 8'h6d, 8'h6e, 8'h6f, 8'h70, 8'h71};
        exps  = '{32'h0a, 32'h0a, 32'h0a, 32'h0, 32'h0, 32'h0};
        {err_count, n_tests} = '0;
        rst_b = 1'b0;
        level = 16'h0;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(addrs[i], v);
            check(v, exps[i]);
        end
        $display("test 1 reset values done");
        wr_rd(8'h6f, 32'hffffffff, v);
        check(v, 32'h0);
        wr_rd(8'h71, 32'hffffffff, v);
        check(v, 32'h0);
        for (int i = 0; i < 3; i++) begin
            wr_rd(addrs[i], 32'h5a5a5a04, v);
            check(v, 32'h04);
        end
        $display("test 2 register access done");
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            level[0] <= ~level[0];
            repeat (5) @(posedge clk);
            #1 check({31'h0, pin_filtered[0]}, {31'h0, level[0]});
        end
        $display("test 3 unfiltered pin done");
        for (int m = 1; m < 4; m++) begin
            u = (m == 1) ? 2 : (m == 2) ? 8 : 16;
            wr_rd(8'h70, {m[1:0], 30'h0}, v);
            check(v, {m[1:0], 30'h0});
            @(posedge clk);
            level[15] <= 1'b1;
            wait_pin(1'b1);
            check({31'h0, (k >= (P - 1) * u) && (k <= P * u + 5)},
                  32'h1);
            @(posedge clk);
            level[15] <= 1'b0;
            repeat (2) @(posedge clk);
            rd(8'h6f, v);
            check(v, 32'h1);
            check({31'h0, filter_pending}, 32'h1);
            wait_pin(1'b0);
            rd(8'h6f, v);
            check(v, 32'h0);
            check({31'h0, filter_pending}, 32'h0);
            // Bounce shorter than the shortest legal length
            level[15] <= 1'b1;
            repeat (u) @(posedge clk);
            level[15] <= 1'b0;
            repeat (P * u + 8) @(posedge clk);
            #1 check({31'h0, pin_filtered[15]}, 32'h0);
            $display("test %0d filter mode %0d done", m + 3, m);
        end
        close_out();
    end
endmodule : pidf_top_test

`default_nettype wire
